/* File: hdl/picirl_pend_bit.sv */
// One pending latch cell
`default_nettype none
module picirl_pend_bit
(
    // Clock and reset
    input wire logic core_clk_in,
    input wire logic resetn_in,
    // Control
    input wire logic set_in,
    input wire logic clr_in,
    // State
    output logic q_out
);
    logic q_q;
    logic q_d;

    // A request in the clearing cycle is kept
    always_comb
    begin
        q_d = set_in | (q_q & ~clr_in);
    end

    always_ff @(posedge core_clk_in)
    begin
        if (!resetn_in)
        begin
            q_q <= 1'b0;
        end
        else
        begin
            q_q <= q_d;
        end
    end

    assign q_out = q_q;
endmodule : picirl_pend_bit
`default_nettype wire

/* File: hdl/picirl_pkg.sv */
// Package of constants for the priority interrupt latch control block
`default_nettype none
package picirl_pkg;
    // ******************************************************************
    // Source layout
    // ******************************************************************
    localparam int N_SRC = 22;
    localparam int IDX_LO = 2;
    localparam int IDX_HI = 21;
    localparam int IDX_EF_LO = 4;
    localparam int IDX_FETCH = 2;
    localparam int IDX_WDOG = 3;
    localparam int IDX_LINE0 = 5;
    localparam int IDX_SPLIT = 16;
    // ******************************************************************
    // Special-function register byte addresses
    // ******************************************************************
    localparam logic [5:0] ADDR_ACCEPT_EXT = 6'h32;
    localparam logic [5:0] ADDR_ACCEPT_LOW = 6'h3A;
    localparam logic [5:0] ADDR_ACCEPT_HIGH = 6'h3B;
    localparam logic [5:0] ADDR_PEND_LOW = 6'h3C;
    localparam logic [5:0] ADDR_PEND_HIGH = 6'h3D;
    localparam logic [5:0] ADDR_PEND_EXT = 6'h3E;
    localparam int MASTER_BIT = 0;
    // ******************************************************************
    // Reset values
    // ******************************************************************
    localparam logic [21:2] PEND_RST = 20'h00000;
    localparam logic [21:4] EF_RST = 18'h00000;
    localparam logic MASTER_RST = 1'b0;
    // ******************************************************************
    // Vector addresses
    // ******************************************************************
    localparam logic [15:0] VEC_RESET = 16'hFFFE;
    localparam logic [15:0] VEC_TRAP = 16'hFFFC;
    localparam logic [15:0] VEC_TOP_A = 16'hFFFE;
    localparam logic [15:0] VEC_TOP_B = 16'hFFBE;
    // ******************************************************************
    // Timing
    // ******************************************************************
    localparam int ACCEPT_MCYC = 8;
    localparam int CLK_PER_MCYC = 4;
    localparam int ACCEPT_CLKS = ACCEPT_MCYC * CLK_PER_MCYC;
    // ******************************************************************
    // Acceptance sequencer
    // ******************************************************************
    typedef enum logic {SEQ_IDLE, SEQ_BUSY} picirl_seq_t;
endpackage : picirl_pkg
`default_nettype wire

/* File: hdl/picirl_select.sv */
// Fixed-order request selector and vector lookup
`default_nettype none
module picirl_select
(
    // Candidates
    input wire logic trap_in,
    input wire logic [21:2] elig_in,
    // Winner
    output logic hit_out,
    output logic is_trap_out,
    output logic [4:0] idx_out,
    output logic [15:0] vec_out
);
    logic [15:0] step;

    always_comb
    begin
        hit_out = 1'b0;
        idx_out = 5'h00;
        // Walk downward so the lowest index wins
        for (int i = picirl_pkg::IDX_HI; i >= picirl_pkg::IDX_LO; i--)
        begin
            if (elig_in[i])
            begin
                hit_out = 1'b1;
                idx_out = 5'(i);
            end
        end
        is_trap_out = trap_in;
        if (trap_in)
        begin
            hit_out = 1'b1;
        end
        step = 16'h0000;
        vec_out = picirl_pkg::VEC_TRAP;
        if (!trap_in)
        begin
            if (idx_out < 5'(picirl_pkg::IDX_SPLIT))
            begin
                step = {10'h000, idx_out, 1'b0};
                vec_out = picirl_pkg::VEC_TOP_A - step;
            end
            else
            begin
                step = {10'h000, 5'(idx_out - 5'(picirl_pkg::IDX_SPLIT)), 1'b0};
                vec_out = picirl_pkg::VEC_TOP_B - step;
            end
        end
    end
endmodule : picirl_select
`default_nettype wire

/* File: hdl/picirl_top.sv */
// Interrupt latch, enable and acceptance control
`default_nettype none
module picirl_top
(
    // Clock and reset
    input wire logic core_clk_in,
    input wire logic resetn_in,
    // Special-function register access
    input wire logic [5:0] sfr_addr_in,
    input wire logic [7:0] sfr_wdata_in,
    input wire logic sfr_wr_in,
    input wire logic sfr_rd_in,
    output logic [7:0] sfr_rdata_out,
    // Request sources
    input wire logic soft_trap_event_in,
    input wire logic bad_opcode_event_in,
    input wire logic fetch_trap_event_in,
    input wire logic watchdog_event_in,
    input wire logic [21:4] src_req_in,
    input wire logic ext_line0_gate_in,
    input wire logic fetch_trap_reset_select_in,
    input wire logic watchdog_reset_select_in,
    // CPU sequencer
    output logic cpu_int_req_out,
    input wire logic cpu_accept_in,
    output logic accept_busy_out,
    output logic [15:0] vector_out,
    output logic stack_master_out,
    input wire logic mask_all_op_in,
    input wire logic unmask_all_op_in,
    input wire logic return_in,
    input wire logic return_master_in,
    // Reset request
    output logic reset_req_out
);
    // ******************************************************************
    // Declarations
    // ******************************************************************
    logic [21:2] pend;
    logic [21:2] set_v;
    logic [21:2] clr_v;
    logic [21:2] elig;
    logic [21:4] ef_q;
    logic [21:4] ef_d;
    logic master_q;
    logic master_d;
    logic trap_lvl;
    logic sel_hit;
    logic sel_trap;
    logic [4:0] sel_idx;
    logic [15:0] sel_vec;
    logic accept_go;
    picirl_pkg::picirl_seq_t seq_q;
    picirl_pkg::picirl_seq_t seq_d;
    logic [5:0] cnt_q;
    logic [5:0] cnt_d;
    logic [15:0] vec_q;
    logic [15:0] vec_d;
    logic stack_q;
    logic stack_d;
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;
    logic rst_req_q;
    logic rst_req_d;
    logic wr_pl;
    logic wr_ph;
    logic wr_pe;

    // ******************************************************************
    // Request latching
    // ******************************************************************
    always_comb
    begin
        set_v = '0;
        // Traps routed to reset never reach their latch
        set_v[picirl_pkg::IDX_FETCH] = fetch_trap_event_in
            & ~fetch_trap_reset_select_in;
        set_v[picirl_pkg::IDX_WDOG] = watchdog_event_in
            & ~watchdog_reset_select_in;
        set_v[21:4] = src_req_in;
    end

    always_comb
    begin
        wr_pl = sfr_wr_in && sfr_addr_in == picirl_pkg::ADDR_PEND_LOW;
        wr_ph = sfr_wr_in && sfr_addr_in == picirl_pkg::ADDR_PEND_HIGH;
        wr_pe = sfr_wr_in && sfr_addr_in == picirl_pkg::ADDR_PEND_EXT;
        clr_v = '0;
        // Only zeros clear; ones are ignored
        if (wr_pl)
        begin
            clr_v[7:2] = ~sfr_wdata_in[7:2];
        end
        if (wr_ph)
        begin
            clr_v[15:8] = ~sfr_wdata_in;
        end
        if (wr_pe)
        begin
            clr_v[21:16] = ~sfr_wdata_in[5:0];
        end
        if (accept_go && !sel_trap)
        begin
            clr_v[sel_idx] = 1'b1;
        end
    end

    generate
        for (genvar g = picirl_pkg::IDX_LO; g <= picirl_pkg::IDX_HI; g++)
        begin : g_pend
            picirl_pend_bit u_bit
            (
                .core_clk_in(core_clk_in),
                .resetn_in(resetn_in),
                .set_in(set_v[g]),
                .clr_in(clr_v[g]),
                .q_out(pend[g])
            );
        end
    endgenerate

    // ******************************************************************
    // Enable gating and selection
    // ******************************************************************
    always_comb
    begin
        // Non-maskable latches need no enable
        elig[3:2] = pend[3:2];
        elig[21:4] = pend[21:4] & ef_q & {18{master_q}};
        elig[picirl_pkg::IDX_LINE0] = pend[picirl_pkg::IDX_LINE0]
            & ef_q[picirl_pkg::IDX_LINE0] & master_q
            & ext_line0_gate_in;
        trap_lvl = soft_trap_event_in | bad_opcode_event_in;
    end

    picirl_select u_sel
    (
        .trap_in(trap_lvl),
        .elig_in(elig),
        .hit_out(sel_hit),
        .is_trap_out(sel_trap),
        .idx_out(sel_idx),
        .vec_out(sel_vec)
    );

    // ******************************************************************
    // Acceptance sequencer
    // ******************************************************************
    // Nesting works because the service routine may raise the master
    // flag again, letting any enabled request through after this one.
    assign cpu_int_req_out = sel_hit && seq_q == picirl_pkg::SEQ_IDLE;
    assign accept_go = cpu_int_req_out && cpu_accept_in;

    always_comb
    begin
        seq_d = seq_q;
        cnt_d = cnt_q;
        vec_d = vec_q;
        stack_d = stack_q;
        unique case (seq_q)
            picirl_pkg::SEQ_IDLE:
            begin
                if (accept_go)
                begin
                    seq_d = picirl_pkg::SEQ_BUSY;
                    cnt_d = 6'(picirl_pkg::ACCEPT_CLKS - 1);
                    vec_d = sel_vec;
                    stack_d = master_q;
                end
            end
            picirl_pkg::SEQ_BUSY:
            begin
                if (cnt_q == 6'h00)
                begin
                    seq_d = picirl_pkg::SEQ_IDLE;
                end
                else
                begin
                    cnt_d = cnt_q - 6'h01;
                end
            end
        endcase
    end

    always_ff @(posedge core_clk_in)
    begin
        if (!resetn_in)
        begin
            seq_q <= picirl_pkg::SEQ_IDLE;
            cnt_q <= 6'h00;
            vec_q <= picirl_pkg::VEC_RESET;
            stack_q <= 1'b0;
        end
        else
        begin
            seq_q <= seq_d;
            cnt_q <= cnt_d;
            vec_q <= vec_d;
            stack_q <= stack_d;
        end
    end

    assign accept_busy_out = seq_q == picirl_pkg::SEQ_BUSY;
    assign vector_out = vec_q;
    assign stack_master_out = stack_q;

    // ******************************************************************
    // Master and source enable flags
    // ******************************************************************
    always_comb
    begin
        ef_d = ef_q;
        master_d = master_q;
        if (sfr_wr_in && sfr_addr_in == picirl_pkg::ADDR_ACCEPT_LOW)
        begin
            ef_d[7:4] = sfr_wdata_in[7:4];
            master_d = sfr_wdata_in[picirl_pkg::MASTER_BIT];
        end
        if (sfr_wr_in && sfr_addr_in == picirl_pkg::ADDR_ACCEPT_HIGH)
        begin
            ef_d[15:8] = sfr_wdata_in;
        end
        if (sfr_wr_in && sfr_addr_in == picirl_pkg::ADDR_ACCEPT_EXT)
        begin
            ef_d[21:16] = sfr_wdata_in[5:0];
        end
        if (unmask_all_op_in)
        begin
            master_d = 1'b1;
        end
        if (mask_all_op_in)
        begin
            master_d = 1'b0;
        end
        if (return_in)
        begin
            master_d = return_master_in;
        end
        // Acceptance has the last word on the master flag
        if (accept_go)
        begin
            master_d = 1'b0;
        end
    end

    always_ff @(posedge core_clk_in)
    begin
        if (!resetn_in)
        begin
            ef_q <= picirl_pkg::EF_RST;
            master_q <= picirl_pkg::MASTER_RST;
        end
        else
        begin
            ef_q <= ef_d;
            master_q <= master_d;
        end
    end

    // ******************************************************************
    // Readback and reset request
    // ******************************************************************
    always_comb
    begin
        rdata_d = rdata_q;
        if (sfr_rd_in)
        begin
            unique case (sfr_addr_in)
                picirl_pkg::ADDR_PEND_LOW: rdata_d = {pend[7:2], 2'b00};
                picirl_pkg::ADDR_PEND_HIGH: rdata_d = pend[15:8];
                picirl_pkg::ADDR_PEND_EXT: rdata_d = {2'b00, pend[21:16]};
                picirl_pkg::ADDR_ACCEPT_LOW: rdata_d = {ef_q[7:4], 3'b000,
                    master_q};
                picirl_pkg::ADDR_ACCEPT_HIGH: rdata_d = ef_q[15:8];
                picirl_pkg::ADDR_ACCEPT_EXT: rdata_d = {2'b00, ef_q[21:16]};
                default: rdata_d = 8'h00;
            endcase
        end
        // A trap set for reset asks for it instead of an interrupt
        rst_req_d = (fetch_trap_event_in & fetch_trap_reset_select_in)
            | (watchdog_event_in & watchdog_reset_select_in);
    end

    always_ff @(posedge core_clk_in)
    begin
        if (!resetn_in)
        begin
            rdata_q <= 8'h00;
            rst_req_q <= 1'b0;
        end
        else
        begin
            rdata_q <= rdata_d;
            rst_req_q <= rst_req_d;
        end
    end

    assign sfr_rdata_out = rdata_q;
    assign reset_req_out = rst_req_q;

    // ******************************************************************
    // Checks
    // ******************************************************************
    a_reset_clears_latch: assert property (@(posedge core_clk_in)
        !resetn_in |=> pend == '0)
        else $error("latches not cleared by reset");
    a_write_never_sets: assert property (@(posedge core_clk_in)
        disable iff (!resetn_in)
        ((pend & ~$past(pend)) & ~$past(set_v)) == '0)
        else $error("latch set without a request");
    a_set_beats_clear: assert property (@(posedge core_clk_in)
        disable iff (!resetn_in)
        (set_v & clr_v) != '0
            |=> (pend & $past(set_v)) == $past(set_v))
        else $error("request lost against a clear");
    a_accept_drops_master: assert property (@(posedge core_clk_in)
        disable iff (!resetn_in)
        accept_go |=> !master_q && stack_master_out == $past(master_q))
        else $error("master flag not dropped or stacked");
    a_seq_eight_mcyc: assert property (@(posedge core_clk_in)
        disable iff (!resetn_in)
        accept_go |=> accept_busy_out ##31 accept_busy_out
            ##1 !accept_busy_out)
        else $error("acceptance sequence length wrong");
    a_vector_held: assert property (@(posedge core_clk_in)
        disable iff (!resetn_in)
        accept_busy_out && $past(accept_busy_out) |-> $stable(vector_out))
        else $error("vector moved during acceptance");
    a_masked_quiet: assert property (@(posedge core_clk_in)
        disable iff (!resetn_in)
        !master_q && !trap_lvl && pend[3:2] == 2'b00
            |-> !cpu_int_req_out)
        else $error("masked request reached the cpu");
    a_fetch_first: assert property (@(posedge core_clk_in)
        disable iff (!resetn_in)
        cpu_int_req_out && !trap_lvl && pend[2]
            |-> sel_vec == 16'hFFFA)
        else $error("fetch trap lost priority");
    a_trap_vector: assert property (@(posedge core_clk_in)
        disable iff (!resetn_in)
        trap_lvl && accept_go |=> vector_out == 16'hFFFC)
        else $error("trap vector wrong");
    a_accept_clears: assert property (@(posedge core_clk_in)
        disable iff (!resetn_in)
        accept_go && !sel_trap && !set_v[sel_idx]
            |=> !pend[$past(sel_idx)])
        else $error("accepted latch still set");
    a_trap_to_reset: assert property (@(posedge core_clk_in)
        disable iff (!resetn_in)
        watchdog_event_in && watchdog_reset_select_in
            |=> reset_req_out && !$rose(pend[3]))
        else $error("watchdog reset select ignored");
endmodule : picirl_top
`default_nettype wire

/* File: tb/picirl_cpu_model.sv */
// CPU sequencer model that accepts offered interrupts
`default_nettype none
module picirl_cpu_model
(
    // Clock and reset
    input wire logic core_clk_in,
    input wire logic resetn_in,
    // Bench control
    input wire logic en_in,
    input wire logic [3:0] dly_in,
    // Controller side
    input wire logic int_req_in,
    output logic accept_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] wait_q = 4'h0;
    logic acc_q = 1'b0;
    // One driver for the accept line, quiet from time zero
    assign accept_out = acc_q;
    // A slow CPU finishes its instruction first; hold until taken
    always @(negedge core_clk_in)
    begin
        if (!resetn_in || !en_in || !int_req_in)
        begin
            acc_q = 1'b0;
            wait_q = dly_in;
        end
        else if (wait_q != 4'h0)
            wait_q = wait_q - 4'h1;
        else
            acc_q = 1'b1;
    end
endmodule : picirl_cpu_model
`default_nettype wire

/* File: tb/priority_interrupt_latch_control_test.sv */
// Self-checking bench for the interrupt latch control block
`default_nettype none
module priority_interrupt_latch_control_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rstn, wr, rd, swi, bad, ftrap, wdog, gate, fsel, wsel;
    logic ireq, acc, busy, stk, mask, unmask, ret, retm, rreq, en;
    logic [5:0] addr;
    logic [7:0] wd, rdata, d;
    logic [21:4] req, r;
    logic [15:0] vec;
    logic [3:0] dly;
    logic [21:2] pend;
    logic master;
    int err_total, n_checks;
    picirl_top dut (.core_clk_in(clk), .resetn_in(rstn),
        .sfr_addr_in(addr), .sfr_wdata_in(wd), .sfr_wr_in(wr),
        .sfr_rd_in(rd), .sfr_rdata_out(rdata), .soft_trap_event_in(swi),
        .bad_opcode_event_in(bad), .fetch_trap_event_in(ftrap),
        .watchdog_event_in(wdog), .src_req_in(req),
        .ext_line0_gate_in(gate), .fetch_trap_reset_select_in(fsel),
        .watchdog_reset_select_in(wsel), .cpu_int_req_out(ireq),
        .cpu_accept_in(acc), .accept_busy_out(busy), .vector_out(vec),
        .stack_master_out(stk), .mask_all_op_in(mask),
        .unmask_all_op_in(unmask), .return_in(ret),
        .return_master_in(retm), .reset_req_out(rreq));
    picirl_cpu_model cpu (.core_clk_in(clk), .resetn_in(rstn),
        .en_in(en), .dly_in(dly), .int_req_in(ireq), .accept_out(acc));
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // ****************************************************************
    // Helpers
    // ****************************************************************
    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : stop_test
    task automatic check(string name, logic [15:0] exp, logic [15:0] got);
        n_checks++;
        if (got !== exp)
        begin
            $display("[ERR] %s expected %h seen %h", name, exp, got);
            err_total++;
        end
    endtask : check
    task automatic sfr_wr(logic [5:0] a, logic [7:0] v);
        @(negedge clk);
        addr = a;
        wd = v;
        wr = 1'b1;
        @(negedge clk);
        wr = 1'b0;
    endtask : sfr_wr
    task automatic sfr_rd(logic [5:0] a, output logic [7:0] v);
        @(negedge clk);
        addr = a;
        rd = 1'b1;
        @(negedge clk);
        rd = 1'b0;
        v = rdata;
    endtask : sfr_rd
    task automatic pulse(ref logic s);
        @(negedge clk);
        s = 1'b1;
        @(negedge clk);
        s = 1'b0;
    endtask : pulse
    task automatic check_latches();
        sfr_rd(6'h3C, d);
        check("latch_low", {8'h00, pend[7:2], 2'b00}, {8'h00, d});
        sfr_rd(6'h3D, d);
        check("latch_high", {8'h00, pend[15:8]}, {8'h00, d});
        sfr_rd(6'h3E, d);
        check("latch_ext", {10'h000, pend[21:16]}, {8'h00, d});
    endtask : check_latches
    function automatic int pick();
        for (int i = 2; i < 22; i++)
            if (pend[i] && (i < 4 || (master && (i != 5 || gate))))
                return i;
        return -1;
    endfunction : pick
    function automatic logic [15:0] vec_of(int i);
        if (i < 16)
            return 16'hFFFE - 16'(2 * i);
        return 16'hFFBE - 16'(2 * (i - 16));
    endfunction : vec_of
    task automatic wait_busy(logic [15:0] v);
        int i;
        for (i = 0; i < 60 && busy !== 1'b1; i++)
            @(posedge clk) #1;
        if (i == 60)
        begin
            err_total++;
            stop_test();
        end
        check("vector", v, vec);
        check("stack_master", {15'h0000, master}, {15'h0000, stk});
        master = 1'b0;
    endtask : wait_busy
    task automatic busy_len();
        int n;
        n = 1;
        while (busy === 1'b1 && n < 40)
        begin
            @(posedge clk) #1;
            n++;
        end
        check("busy_cycles", 16'h0021, 16'(n));
    endtask : busy_len
    task automatic drain();
        int i;
        for (int k = 0; k < 24; k++)
        begin
            // Hold the CPU off until the master flag is really up
            en = 1'b0;
            pulse(unmask);
            master = 1'b1;
            i = pick();
            if (i < 0)
                break;
            dly = 4'($urandom_range(0, 3));
            en = 1'b1;
            wait_busy(vec_of(i));
            pend[i] = 1'b0;
            busy_len();
        end
        check("int_req_idle", 16'h0000, {15'h0000, ireq});
        check_latches();
    endtask : drain
    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial
    begin
        {rstn, wr, rd, swi, bad, ftrap, wdog, mask, unmask} = '0;
        {ret, retm, en, master} = '0;
        {addr, wd, req, dly, pend} = '0;
        {gate, fsel, wsel} = 3'b111;
        err_total = 0;
        n_checks = 0;
        repeat (8) @(negedge clk);
        rstn = 1'b1;
        void'($urandom(32'hD21EAE9B));
        check_latches();
        check("vector_rst", 16'hFFFE, vec);
        sfr_rd(6'h10, d);
        check("unmapped", 16'h0000, {8'h00, d});
        sfr_wr(6'h3A, 8'hFE);
        sfr_wr(6'h3B, 8'hFF);
        sfr_wr(6'h32, 8'hFF);
        sfr_rd(6'h3A, d);
        check("accept_low", 16'h00F0, {8'h00, d});
        sfr_rd(6'h32, d);
        check("accept_ext", 16'h003F, {8'h00, d});
        r = 18'($urandom);
        r[5] = 1'b1;
        @(negedge clk);
        req = r;
        @(negedge clk);
        req = '0;
        pend[21:4] = r;
        check("int_req_masked", 16'h0000, {15'h0000, ireq});
        check_latches();
        // Keep line 0 pending so the gate test has something to hold
        d = 8'($urandom) | 8'h2C;
        sfr_wr(6'h3C, d);
        pend[7:4] = pend[7:4] & d[7:4];
        @(negedge clk);
        addr = 6'h3D;
        wd = 8'h00;
        wr = 1'b1;
        req[8] = 1'b1;
        @(negedge clk);
        {wr, req} = '0;
        pend[15:8] = 8'h01;
        sfr_wr(6'h3E, 8'hFF);
        check_latches();
        en = 1'b1;
        gate = 1'b0;
        drain();
        gate = 1'b1;
        drain();
        // Trap latches are non-maskable: keep the CPU off while they fill
        en = 1'b0;
        {fsel, wsel} = 2'b00;
        pulse(ftrap);
        pulse(wdog);
        pend[3:2] = 2'b11;
        check_latches();
        pulse(mask);
        master = 1'b0;
        @(negedge clk);
        swi = 1'b1;
        en = 1'b1;
        wait_busy(16'hFFFC);
        @(negedge clk);
        swi = 1'b0;
        busy_len();
        @(negedge clk);
        bad = 1'b1;
        wait_busy(16'hFFFC);
        @(negedge clk);
        bad = 1'b0;
        busy_len();
        drain();
        {fsel, wsel} = 2'b11;
        for (int k = 0; k < 2; k++)
        begin
            @(negedge clk);
            {ftrap, wdog} = k ? 2'b01 : 2'b10;
            @(negedge clk);
            {ftrap, wdog} = 2'b00;
            check("reset_req", 16'h0001, {15'h0000, rreq});
            @(negedge clk);
            check("reset_req_end", 16'h0000, {15'h0000, rreq});
        end
        check_latches();
        pulse(mask);
        retm = 1'b1;
        pulse(ret);
        sfr_rd(6'h3A, d);
        check("master_restore", 16'h00F1, {8'h00, d});
        en = 1'b0;
        @(negedge clk);
        req = 18'h3FFFF;
        @(negedge clk);
        req = '0;
        rstn = 1'b0;
        repeat (2) @(negedge clk);
        rstn = 1'b1;
        pend = '0;
        check_latches();
        stop_test();
    end
endmodule : priority_interrupt_latch_control_test
`default_nettype wire
